// ---- hdl/sleep_wake_consts.svh ----
// constants for the sleep, wake and watchdog block
`ifndef SLEEP_WAKE_CONSTS_SVH
`define SLEEP_WAKE_CONSTS_SVH

// register port offsets
`define SWW_ADDR_STATUS  2'h0
`define SWW_ADDR_CAUSE   2'h1
`define SWW_ADDR_COUNT   2'h2

// status register field positions
`define SWW_ST_PDF       0
`define SWW_ST_TO        1

// reset values
`define SWW_RDATA_RST    8'h00
`define SWW_CAUSE_RST    4'h0

// wake delay in system clock periods
`define SWW_WAKE_CYC     1024
// system clock divider for the watchdog
`define SWW_SYSTEM_CLOCK_FREQ_DIV     4
// main clock period
`define SWW_CLK_NS       5
// private watchdog oscillator period
`define SWW_DOG_OSC_NS   65000
`define SWW_DOG_OSC_CYC  (`SWW_DOG_OSC_NS / `SWW_CLK_NS)
// width of the watchdog ripple counter
`define SWW_DIV_BITS     15

`endif

// ---- hdl/sleep_wake_pkg.sv ----
// types shared by the sleep, wake and watchdog block
package sleep_wake_pkg;

    // power state, gray along run, sleep, wake
    typedef enum logic [1:0] {
        ST_RUN   = 2'h0,
        ST_SLEEP = 2'h1,
        ST_WAKE  = 2'h3
    } pwr_state_t;

    // last half clear seen in pair mode
    typedef enum logic [1:0] {
        HALF_NONE   = 2'h0,
        HALF_FIRST  = 2'h1,
        HALF_SECOND = 2'h2
    } clr_half_t;

    // watchdog clear strobes from the core
    typedef struct packed {
        logic dog_clear_single;
        logic dog_clear_first_half;
        logic dog_clear_second_half;
    } dog_cmd_t;

    // wake source bits
    typedef struct packed {
        logic dog;
        logic irq;
        logic porta;
        logic ext;
    } wake_cause_t;

endpackage

// ---- hdl/sleep_wake_watchdog.sv ----
// power-down, wake sequencing and watchdog supervision
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "sleep_wake_consts.svh"

module sleep_wake_watchdog #(
    parameter bit          DOG_ENABLE  = 1'b1,
    parameter bit          DOG_SRC_OSC = 1'b1,
    parameter bit          DOG_PAIR    = 1'b0,
    parameter int          PORTA_W     = 8,
    parameter logic [7:0]  WAKE_MASK   = 8'hFF,
    parameter int          IRQ_W       = 4,
    parameter int          DOG_OSC_CYC = `SWW_DOG_OSC_CYC
) (
    // clock, reset, enable
    input  wire logic                       mclk_i,
    input  wire logic                       rstn_i,
    input  wire logic                       ce_i,
    // core instruction strobes
    input  wire logic                       sleep_exec_i,
    input  wire sleep_wake_pkg::dog_cmd_t   dog_cmd_i,
    // core interrupt state
    input  wire logic [IRQ_W-1:0]           irq_req_i,
    input  wire logic [IRQ_W-1:0]           irq_en_i,
    input  wire logic                       stack_full_i,
    // pins
    input  wire logic                       board_level_init_pin_n_i,
    input  wire logic [PORTA_W-1:0]         porta_i,
    // register port
    input  wire logic [1:0]                 addr_i,
    input  wire logic [7:0]                 wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [7:0]                 rdata_o,
    // control toward the core
    output logic                            osc_run_o,
    output logic                            halt_o,
    output logic                            sys_reset_o,
    output logic                            pc_sp_reset_o,
    output logic                            vector_irq_o,
    // status flags
    output logic                            power_down_flag_o,
    output logic                            watchdog_expiry_flag_o
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks and derived constants
    localparam int OSC_W = $clog2(DOG_OSC_CYC + 1);  // a count of one ticks every clock
    localparam int DIV_W = `SWW_DIV_BITS;
    localparam logic [10:0] WAKE_LAST = 11'(`SWW_WAKE_CYC - 1);
    localparam logic [1:0]  PRE_LAST  = 2'(`SWW_SYSTEM_CLOCK_FREQ_DIV - 1);
    localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(DOG_OSC_CYC - 1);

    // port mask and counters must fit the logic
    if (PORTA_W < 1 || PORTA_W > 8 || IRQ_W < 1 || DOG_OSC_CYC < 1) begin : g_bad_par
        $error("PORTA_W, IRQ_W or DOG_OSC_CYC out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    sleep_wake_pkg::pwr_state_t  state_r, state_nxt;    // power state
    sleep_wake_pkg::clr_half_t   half_r, half_nxt;      // pair mode history
    sleep_wake_pkg::wake_cause_t cause_r;               // sticky wake causes
    sleep_wake_pkg::wake_cause_t wake_nxt;              // causes this cycle
    logic [PORTA_W-1:0] pa_s1_r, pa_s2_r, pa_s3_r;      // port sync 1, 2, edge history
    logic               rp_s1_r, rp_s2_r;               // reset pin sync 1, 2
    logic [OSC_W-1:0]   osc_cnt_r;            // private oscillator
    logic [1:0]         pre_r;                // system_clock_freq/4 prescaler
    logic [DIV_W-1:0]   div_r;                // 15-bit stage
    logic               last_r;               // clearable last stage
    logic [10:0]        dly_r;                // wake delay counter
    logic [IRQ_W-1:0]   irq_mask_r, irq_woke_r;         // pending at sleep, irq that woke us
    logic               wake_ext_r, wake_dog_r;         // woken by reset pin, by overflow
    logic               vec_pend_r;                     // vector next cycle
    logic               pdf_r, to_r;                    // status flags
    logic [7:0]         rdata_r;                        // read data
    logic               osc_run_r, halt_r, sys_reset_r, pc_sp_r, vector_r; // output flops

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire run_st   = (state_r == sleep_wake_pkg::ST_RUN);
    wire sleep_st = (state_r == sleep_wake_pkg::ST_SLEEP);
    wire wake_st  = (state_r == sleep_wake_pkg::ST_WAKE);
    wire pin_low  = ~rp_s2_r;
    // sleep taken only from run and only by the strobe
    wire sleep_take = ce_i & run_st & sleep_exec_i & ~pin_low;
    // clear strobes are no-ops when the dog is disabled
    wire cmd_ok     = ce_i & run_st & DOG_ENABLE;
    wire single_hit = cmd_ok & ~DOG_PAIR & dog_cmd_i.dog_clear_single;
    wire first_hit  = cmd_ok & DOG_PAIR & dog_cmd_i.dog_clear_first_half;
    wire second_hit = cmd_ok & DOG_PAIR & dog_cmd_i.dog_clear_second_half;
    // only the opposite half completes a clear
    wire pair_done  = (first_hit & (half_r == sleep_wake_pkg::HALF_SECOND))
                    | (second_hit & (half_r == sleep_wake_pkg::HALF_FIRST));
    wire dog_clr_cmd = single_hit | pair_done;
    // sleep and clear instructions clear the last stage
    wire stage_clr  = sleep_take | dog_clr_cmd;

    // private oscillator tick, one per nominal period
    wire osc_tick = (osc_cnt_r == OSC_LAST);
    // system_clock_freq/4 tick stops while the system oscillator is off
    wire pre_tick = (pre_r == PRE_LAST) & ~sleep_st;
    wire src_tick = DOG_SRC_OSC ? osc_tick : pre_tick;
    wire dog_tick = ce_i & DOG_ENABLE & src_tick;
    wire carry    = &div_r;
    // overflow of the last stage
    wire expire   = dog_tick & carry & last_r & ~pin_low;

    // wake event detection
    wire [PORTA_W-1:0] pa_fall = pa_s3_r & ~pa_s2_r & WAKE_MASK[PORTA_W-1:0];
    wire [IRQ_W-1:0]   irq_new = irq_req_i & ~irq_mask_r;
    wire wake_any = pin_low | (|pa_fall) | (|irq_new) | expire;
    wire wake_end = ce_i & wake_st & (dly_r == WAKE_LAST);
    // vector only if the waking irq is enabled and stack has room
    wire irq_ok   = (|(irq_woke_r & irq_en_i)) & ~stack_full_i;

    // register port selects
    wire sel_status = (addr_i == `SWW_ADDR_STATUS);
    wire sel_cause  = (addr_i == `SWW_ADDR_CAUSE);
    wire sel_count  = (addr_i == `SWW_ADDR_COUNT);
    wire cause_wr   = ce_i & wr_i & sel_cause;
    wire [7:0] rd_val = sel_status ? {4'h0, state_r, to_r, pdf_r}
                      : sel_cause  ? {4'h0, cause_r}
                      : sel_count  ? div_r[DIV_W-1:DIV_W-8]
                      : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // next state and wake cause
    always_comb begin
        state_nxt = state_r;
        wake_nxt  = '0;
        case (state_r)
            sleep_wake_pkg::ST_RUN: begin
                if (sleep_take) begin
                    state_nxt = sleep_wake_pkg::ST_SLEEP;
                end
            end
            sleep_wake_pkg::ST_SLEEP: begin
                if (ce_i && wake_any) begin
                    state_nxt = sleep_wake_pkg::ST_WAKE;
                    wake_nxt  = {expire, |irq_new, |pa_fall, pin_low};
                end
            end
            sleep_wake_pkg::ST_WAKE: begin
                // core stays stalled until terminal count
                if (wake_end) begin
                    state_nxt = sleep_wake_pkg::ST_RUN;
                end
            end
            default: begin
                state_nxt = sleep_wake_pkg::ST_RUN;
            end
        endcase
    end

    // pair mode history
    always_comb begin
        half_nxt = half_r;
        if (pair_done) begin
            half_nxt = sleep_wake_pkg::HALF_NONE;
        end else if (first_hit) begin
            half_nxt = sleep_wake_pkg::HALF_FIRST;
        end else if (second_hit) begin
            half_nxt = sleep_wake_pkg::HALF_SECOND;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, idle high so no false edge after reset
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            {pa_s1_r, pa_s2_r, pa_s3_r} <= '1;
            {rp_s1_r, rp_s2_r}          <= 2'h3;
        end else if (ce_i) begin
            {pa_s3_r, pa_s2_r, pa_s1_r} <= {pa_s2_r, pa_s1_r, porta_i};
            {rp_s2_r, rp_s1_r}          <= {rp_s1_r, board_level_init_pin_n_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog clock sources
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            osc_cnt_r <= '0;
            pre_r     <= 2'h0;
        end else if (ce_i) begin
            // private oscillator runs in every state
            osc_cnt_r <= osc_tick ? '0 : osc_cnt_r + 1'b1;
            // system_clock_freq/4 frozen with the system clock
            if (!sleep_st) begin
                pre_r <= pre_r + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog divider chain
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            div_r  <= '0;
            last_r <= 1'b0;
        end else if (ce_i) begin
            if (pin_low || !DOG_ENABLE) begin
                // low pin clears the whole count
                div_r  <= '0;
                last_r <= 1'b0;
            end else begin
                if (dog_tick) begin
                    div_r <= div_r + 1'b1;
                end
                if (stage_clr) begin
                    last_r <= 1'b0;
                end else if (dog_tick && carry) begin
                    last_r <= ~last_r;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power sequencing
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            state_r    <= sleep_wake_pkg::ST_RUN;
            half_r     <= sleep_wake_pkg::HALF_NONE;
            dly_r      <= 11'h000;
            {irq_mask_r, irq_woke_r} <= '0;
            {wake_ext_r, wake_dog_r} <= 2'h0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            half_r  <= half_nxt;
            if (sleep_take) begin
                // requests pending now cannot wake us
                irq_mask_r <= irq_req_i;
            end
            if (sleep_st) begin
                dly_r      <= 11'h000;
                irq_woke_r <= irq_new;
                wake_ext_r <= pin_low;
                wake_dog_r <= expire;
            end else if (wake_st) begin
                // delay runs on the restarted clock
                dly_r <= dly_r + 11'h001;
                if (pin_low) begin
                    wake_ext_r <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags, set wins over clear
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            {pdf_r, to_r} <= 2'h0;
            cause_r <= `SWW_CAUSE_RST;
        end else if (ce_i) begin
            if (sleep_take) begin
                pdf_r <= 1'b1;
            end else if (dog_clr_cmd) begin
                pdf_r <= 1'b0;
            end
            if (expire) begin
                to_r <= 1'b1;
            end else if (sleep_take) begin
                to_r <= 1'b0;
            end
            cause_r <= wake_nxt | (cause_r & ~(cause_wr ? wdata_i[3:0] : 4'h0));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            rdata_r     <= `SWW_RDATA_RST;
            osc_run_r   <= 1'b1;
            {halt_r, sys_reset_r, pc_sp_r, vec_pend_r, vector_r} <= 5'h00;
        end else if (ce_i) begin
            rdata_r   <= rd_i ? rd_val : 8'h00;
            // oscillator off only in sleep
            osc_run_r <= (state_nxt != sleep_wake_pkg::ST_SLEEP);
            // core and ports frozen while not running
            halt_r    <= (state_nxt != sleep_wake_pkg::ST_RUN);
            // full reset from pin, or overflow in run
            sys_reset_r <= pin_low | (run_st & expire)
                         | (wake_st & wake_ext_r);
            // overflow wake resets only pc and sp
            pc_sp_r    <= wake_end & wake_dog_r & ~wake_ext_r;
            // otherwise resume at next instruction
            vec_pend_r <= wake_end & ~wake_ext_r & ~wake_dog_r & irq_ok;
            vector_r   <= vec_pend_r;
        end
    end

    assign rdata_o                = rdata_r;
    assign osc_run_o              = osc_run_r;
    assign halt_o                 = halt_r;
    assign sys_reset_o            = sys_reset_r;
    assign pc_sp_reset_o          = pc_sp_r;
    assign vector_irq_o           = vector_r;
    assign power_down_flag_o      = pdf_r;
    assign watchdog_expiry_flag_o = to_r;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);
    sequence s_wake_exit;
        wake_end && !wake_ext_r && !pin_low;
    endsequence
    sequence s_irq_go;
        s_wake_exit ##0 (!wake_dog_r && irq_ok) ##1 ce_i;
    endsequence

    a_sleep_entry: assert property (sleep_take |=> sleep_st && !osc_run_o && halt_o)
        else $error("sleep entry did not stop oscillator and core");
    a_sleep_flags: assert property (sleep_take && !expire |=> pdf_r && !to_r)
        else $error("sleep did not set pdf and clear to");
    a_wake_delay: assert property ($fell(halt_o) |-> $past(dly_r) == WAKE_LAST)
        else $error("core released before wake delay ended");
    a_wake_stall: assert property (wake_st && !wake_end |=> halt_o)
        else $error("core not stalled during wake delay");
    a_irq_vector: assert property (s_irq_go |=> vector_irq_o)
        else $error("enabled wake irq not vectored");
    a_irq_resume: assert property (s_wake_exit ##0 !irq_ok |=> ##1 !vector_irq_o)
        else $error("vector issued for disabled irq or full stack");
    a_dog_sleep: assert property (s_wake_exit ##0 wake_dog_r |=> pc_sp_reset_o && !sys_reset_o)
        else $error("sleep overflow did not reset pc and sp only");
    a_dog_run: assert property (run_st && expire |=> sys_reset_o && to_r)
        else $error("run overflow did not reset and set to");
    a_pdf_clear: assert property (dog_clr_cmd |=> !pdf_r)
        else $error("dog clear left pdf set");
    a_pair_order: assert property ((first_hit && half_r != sleep_wake_pkg::HALF_SECOND)
        || (second_hit && half_r != sleep_wake_pkg::HALF_FIRST) |-> !dog_clr_cmd)
        else $error("pair clear without a prior opposite half");
    a_ext_reset: assert property (pin_low && ce_i |=> sys_reset_o)
        else $error("reset pin did not reset device");
    a_last_clear: assert property (stage_clr && !pin_low && DOG_ENABLE |=> !last_r)
        else $error("clear left last stage set");

endmodule // sleep_wake_watchdog

// ---- test/core_model.sv ----
// model of the core that issues sleep and watchdog clear strobes
`timescale 1ns/10ps
module core_model #(
    parameter bit PAIR = 1'b0
) (
    // clock and stall
    input  wire logic                mclk_i,
    input  wire logic                halt_i,
    // strobes toward the block
    output logic                     sleep_exec_o,
    output sleep_wake_pkg::dog_cmd_t dog_cmd_o
);
    // strobes idle at time zero
    initial begin
        sleep_exec_o = 1'b0;
        dog_cmd_o    = 3'h0;
    end
    // a stalled core issues nothing
    task automatic wait_run();
        while (halt_i !== 1'b0) @(posedge mclk_i);
    endtask
    // sleep instruction, one-cycle strobe
    task automatic do_sleep();
        wait_run();
        @(posedge mclk_i);
        sleep_exec_o <= 1'b1;
        @(posedge mclk_i);
        sleep_exec_o <= 1'b0;
        #1;
    endtask
    // clear: single strobe, or both halves in turn
    task automatic do_clear();
        wait_run();
        @(posedge mclk_i);
        if (PAIR) begin
            dog_cmd_o <= 3'h2;
            @(posedge mclk_i);
            dog_cmd_o <= 3'h1;
        end else begin
            dog_cmd_o <= 3'h4;
        end
        @(posedge mclk_i);
        dog_cmd_o <= 3'h0;
        #1;
    endtask
endmodule // core_model

// ---- test/testbench.sv ----
// self-checking bench for the sleep, wake and watchdog block
`timescale 1ns/10ps
module testbench;
    ////////////////////////////////////////////////////////////
    logic                     mclk_i, rstn_i, stack_full_i, pin_n_i;
    logic [3:0]               irq_req_i, irq_en_i;
    logic [7:0]               porta_i, wdata_i, rdata_o;
    logic [1:0]               addr_i;
    logic                     wr_i, rd_i, osc_run_o, halt_o, sys_reset_o;
    logic                     pc_sp_reset_o, vector_irq_o, pdf_o, to_o, sleep_exec;
    sleep_wake_pkg::dog_cmd_t dog_cmd;
    int                       err_total, n_tests, n;
    // block under test, fast private watchdog clock
    sleep_wake_watchdog #(.DOG_OSC_CYC(1)) dut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1), .sleep_exec_i(sleep_exec),
        .dog_cmd_i(dog_cmd), .irq_req_i(irq_req_i), .irq_en_i(irq_en_i),
        .stack_full_i(stack_full_i), .board_level_init_pin_n_i(pin_n_i), .porta_i(porta_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .osc_run_o(osc_run_o), .halt_o(halt_o), .sys_reset_o(sys_reset_o),
        .pc_sp_reset_o(pc_sp_reset_o), .vector_irq_o(vector_irq_o),
        .power_down_flag_o(pdf_o), .watchdog_expiry_flag_o(to_o));
    // core partner
    core_model core (.mclk_i(mclk_i), .halt_i(halt_o), .sleep_exec_o(sleep_exec), .dog_cmd_o(dog_cmd));
    // 200 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    ////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic end_sim();
        if (err_total == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // compare one flag
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // compare a value or count
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // register write, one cycle
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask
    // register read, data checked in the following cycle
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1 chk_val({8'h00, rdata_o}, {8'h00, e});
    endtask
    // count edges until the core stall drops
    task automatic wait_low(input int lim, output int c);
        c = 0;
        do begin
            @(posedge mclk_i);
            #1 c++;
        end while (halt_o !== 1'b0 && c < lim);
    endtask
    ////////////////////////////////////////////////////////////
    // watchdog against a hang
    initial begin
        #450000;
        err_total++;
        end_sim();
    end
    // main sequence
    initial begin
        {rstn_i, stack_full_i, wr_i, rd_i, addr_i, wdata_i, irq_req_i} = '0;
        {pin_n_i, irq_en_i, porta_i} = {1'b1, 4'h1, 8'hFF};
        repeat (20) @(posedge mclk_i);
        rstn_i <= 1'b1;
        rd(2'h0, 8'h00);
        rd(2'h3, 8'h00);
        // sleep entry, then a new enabled request wakes and vectors
        core.do_sleep();
        chk_bit(halt_o, 1'b1);
        chk_bit(osc_run_o, 1'b0);
        chk_bit(pdf_o, 1'b1);
        chk_bit(to_o, 1'b0);
        rd(2'h0, 8'h05);
        @(posedge mclk_i);
        irq_req_i <= 4'h1;
        wait_low(1100, n);
        chk_val(16'(n), 16'h0401);
        @(posedge mclk_i);
        #1 chk_bit(vector_irq_o, 1'b1);
        rd(2'h1, 8'h04);
        wr(2'h1, 8'h0F);
        rd(2'h1, 8'h00);
        core.do_clear();
        chk_bit(pdf_o, 1'b0);
        wr(2'h0, 8'hFF);
        rd(2'h0, 8'h00);
        // a request already set at sleep cannot wake; a port edge does
        core.do_sleep();
        repeat (40) @(posedge mclk_i);
        #1 chk_bit(halt_o, 1'b1);
        @(posedge mclk_i);
        porta_i <= 8'hF7;
        wait_low(1100, n);
        chk_bit(halt_o, 1'b0);
        @(posedge mclk_i);
        porta_i <= 8'hFF;
        #1 chk_bit(vector_irq_o, 1'b0);
        rd(2'h1, 8'h02);
        // disabled request, then full stack: resume without vectoring
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk_i);
            irq_req_i    <= 4'h0;
            irq_en_i     <= k[0] ? 4'hF : 4'h0;
            stack_full_i <= k[0];
            core.do_sleep();
            @(posedge mclk_i);
            irq_req_i <= 4'h2;
            wait_low(1100, n);
            chk_val(16'(n), 16'h0401);
            @(posedge mclk_i);
            #1 chk_bit(vector_irq_o, 1'b0);
        end
        // overflow while asleep on the private watchdog clock
        @(posedge mclk_i);
        irq_req_i    <= 4'h0;
        stack_full_i <= 1'b0;
        core.do_sleep();
        wait_low(70000, n);
        chk_bit(pc_sp_reset_o, 1'b1);
        chk_bit(to_o, 1'b1);
        chk_bit(pdf_o, 1'b1);
        chk_bit(sys_reset_o, 1'b0);
        chk_bit(1'(n > 33792 && n < 66570), 1'b1);
        // reset pin wake gives a full reset
        core.do_sleep();
        @(posedge mclk_i);
        pin_n_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        #1 chk_bit(sys_reset_o, 1'b1);
        @(posedge mclk_i);
        pin_n_i <= 1'b1;
        wait_low(1200, n);
        chk_bit(halt_o, 1'b0);
        end_sim();
    end
endmodule // testbench
